// ===== rtl/fdmcc_pkg.sv
/*
  Shared constants for the flash command sequencer and its core port:
  register selects, command codes, array sizes, reset values and timing.
  Assumes a 100 MHz sys_clk and one machine cycle per MC_CLKS clocks.
*/
package fdmcc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MC_CLKS = 1;

  // Register selects on the link
  localparam logic [2:0] SEL_CMD     = 3'h0;
  localparam logic [2:0] SEL_DATA1   = 3'h1;
  localparam logic [2:0] SEL_DATA4   = 3'h4;
  localparam logic [2:0] SEL_ADDR_HI = 3'h5;
  localparam logic [2:0] SEL_ADDR_LO = 3'h6;

  // Command codes
  localparam logic [7:0] CMD_PAGE_RD = 8'h01;
  localparam logic [7:0] CMD_PAGE_WR = 8'h02;
  localparam logic [7:0] CMD_VERIFY  = 8'h04;
  localparam logic [7:0] CMD_PAGE_ER = 8'h05;
  localparam logic [7:0] CMD_ALL_ER  = 8'h06;
  localparam logic [7:0] CMD_BYTE_RD = 8'h81;
  localparam logic [7:0] CMD_BYTE_WR = 8'h82;
  localparam logic [7:0] CMD_UPD_OFF = 8'h0F;
  localparam logic [7:0] CMD_UPD_ON  = 8'hF0;

  // Array geometry and limits
  localparam int unsigned DF_BYTES       = 4096;
  localparam int unsigned PF_UPD_BYTES   = 57344;
  localparam int unsigned INTERNAL_EXTERNAL_RAM_BYTES     = 256;
  localparam logic [15:0] PAGE_BYTES     = 16'h0004;
  localparam logic [15:0] BYTE_LEN       = 16'h0001;
  localparam logic [15:0] DF_ALL_LEN     = 16'h1000;
  localparam logic [15:0] UPD_WR_LEN     = 16'h0101;
  localparam logic [15:0] UPD_ER_LEN     = 16'h0040;
  localparam logic [15:0] UPD_ALL_LEN    = 16'hE000;
  localparam logic [15:0] DF_PAGE_LIMIT  = 16'h0400;
  localparam logic [15:0] DF_BYTE_MAX    = 16'h0FFF;
  localparam logic [15:0] UPD_BYTE_MAX   = 16'hDFFF;
  localparam logic [7:0]  UPD_PAGE_LIMIT = 8'hE0;

  // Values
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] VERIFY_OK  = 8'h00;
  localparam logic [7:0] VERIFY_BAD = 8'h01;

  // Durations as printed, then cycle counts
  localparam int unsigned PAGE_RD_MC = 25;
  localparam int unsigned BYTE_RD_MC = 10;
  localparam int unsigned PAGE_WR_US = 380;
  localparam int unsigned BYTE_WR_US = 200;
  localparam int unsigned ERASE_MS   = 2;
  localparam int unsigned UPD_WR_MS  = 15;
  localparam int unsigned PAGE_RD_CYC = PAGE_RD_MC * MC_CLKS;
  localparam int unsigned BYTE_RD_CYC = BYTE_RD_MC * MC_CLKS;
  localparam int unsigned PAGE_WR_CYC = PAGE_WR_US * CLK_MHZ;
  localparam int unsigned BYTE_WR_CYC = BYTE_WR_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC   = ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned UPD_WR_CYC  = UPD_WR_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    OP_NONE, OP_PG_RD, OP_PG_WR, OP_VERIFY, OP_PG_ER, OP_ALL_ER, OP_BY_RD, OP_BY_WR
  } fdmcc_op_t;
endpackage

// ===== rtl/fdmcc_link_if.sv
/*
  Register link between the core side and the flash sequencer.
  Assumes both ends run on the same sys_clk; no clock lives here.
*/
`timescale 1ns/1ps
interface fdmcc_link_if;
  logic [2:0] sel;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       stall;
  logic [7:0] internal_external_ram_addr;
  logic [7:0] internal_external_ram_rdata;

  modport dev (input sel, wr, rd, wdata, internal_external_ram_rdata,
               output rdata, rvalid, stall, internal_external_ram_addr);
  modport core (output sel, wr, rd, wdata, internal_external_ram_rdata,
                input rdata, rvalid, stall, internal_external_ram_addr);
endinterface

// ===== rtl/fdmcc_flash_ctrl.sv
/*
  Flash command sequencer: command, data and address registers, the
  data flash array, the updatable program flash region and its timing.
  Assumes the core end stalls while stall is high and answers internal_external_ram_addr
  with internal_external_ram_rdata one clock later.
*/
// Function
// - Data flash: 1024 pages of four bytes
// - Address from high and low byte registers
// - Eight-bit command register, nine defined commands
// - Normal 01H reads page into data registers
// - Normal 02H programs page below 0400H
// - Normal 04H compares; command read gives result
// - Normal 05H erases one data page
// - Normal 06H erases whole data array
// - Normal 82H programs first register to byte
// - F0H enters program-update mode
// - 0FH returns to normal mode
// - Update page write copies 256 buffer bytes
// - Update page erase clears 64-byte page
// - Update erase-all clears updatable region
// - Update byte write up to DFFFH
// - Update reads and verify are unimplemented
// - Software programs only erased bytes
// - Operation starts when command is written
// - Core stalls until operation finishes
// - Durations follow the typical timing table
// - Top region never written by updates
`timescale 1ns/1ps
module fdmcc_flash_ctrl #(
  parameter int unsigned PAGE_WR_CYCLES = fdmcc_pkg::PAGE_WR_CYC,
  parameter int unsigned BYTE_WR_CYCLES = fdmcc_pkg::BYTE_WR_CYC,
  parameter int unsigned ERASE_CYCLES   = fdmcc_pkg::ERASE_CYC,
  parameter int unsigned UPD_WR_CYCLES  = fdmcc_pkg::UPD_WR_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  fdmcc_link_if.dev        lnk,
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_data,
  output logic             update_mode
);
  typedef enum logic {ST_IDLE, ST_RUN} fdmcc_st_t;

  typedef struct packed {
    fdmcc_st_t            st;
    logic                 upd;
    fdmcc_pkg::fdmcc_op_t op;
    logic [3:0][7:0]      data;
    logic [7:0]           addr_hi;
    logic [7:0]           addr_lo;
    logic [7:0]           cmd_rb;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 mism;
    logic [15:0]          base;
    logic [15:0]          idx;
    logic [15:0]          len;
    logic [31:0]          cnt;
    logic [7:0]           code_q;
  } fdmcc_dev_t;

  fdmcc_dev_t r_reg;
  fdmcc_dev_t r_next;

  logic [7:0]  df_mem [0:fdmcc_pkg::DF_BYTES-1];
  logic [7:0]  pf_mem [0:fdmcc_pkg::PF_UPD_BYTES-1];
  logic        df_we;
  logic        pf_we;
  logic [11:0] df_a;
  logic [15:0] pf_a;
  logic [7:0]  mem_wd;
  logic [7:0]  df_rd;
  logic [7:0]  pf_rd;
  logic [15:0] addr;

  assign addr  = {r_reg.addr_hi, r_reg.addr_lo};
  assign df_a  = r_reg.base[11:0] + r_reg.idx[11:0];
  assign pf_a  = (r_reg.upd && r_reg.op == fdmcc_pkg::OP_PG_WR) ?
                 r_reg.base + r_reg.idx - 16'h0001 : r_reg.base + r_reg.idx;
  assign df_rd = df_mem[df_a];
  assign pf_rd = (pf_a < fdmcc_pkg::UPD_ALL_LEN) ? pf_mem[pf_a] : fdmcc_pkg::ERASED;

  // Outputs straight from state
  assign lnk.rdata     = r_reg.rdata;
  assign lnk.rvalid    = r_reg.rvalid;
  assign lnk.internal_external_ram_addr = r_reg.idx[7:0];
  assign code_data     = r_reg.code_q;
  assign update_mode   = r_reg.upd;
  // Stall from the clock after the command write until done; registered so
  // the core's ready and write strobe form no loop through it
  assign lnk.stall = (r_reg.st == ST_RUN);

  // Next state, register access and sequencing
  always_comb begin
    fdmcc_pkg::fdmcc_op_t op;
    logic [15:0] ln;
    logic [15:0] bs;
    int unsigned cy;
    op     = fdmcc_pkg::OP_NONE;
    ln     = 16'h0000;
    bs     = 16'h0000;
    cy     = 1;
    r_next = r_reg;
    df_we  = 1'b0;
    pf_we  = 1'b0;
    mem_wd = fdmcc_pkg::ERASED;
    r_next.rvalid = 1'b0;
    r_next.code_q = (code_addr < fdmcc_pkg::UPD_ALL_LEN) ? pf_mem[code_addr] :
                    fdmcc_pkg::ERASED;
    // Register reads, answered one clock later
    if (lnk.rd) begin
      r_next.rvalid = 1'b1;
      if (lnk.sel == fdmcc_pkg::SEL_CMD) begin
        r_next.rdata = r_reg.cmd_rb;
      end else if (lnk.sel >= fdmcc_pkg::SEL_DATA1 && lnk.sel <= fdmcc_pkg::SEL_DATA4) begin
        r_next.rdata = r_reg.data[2'(lnk.sel - fdmcc_pkg::SEL_DATA1)];
      end else if (lnk.sel == fdmcc_pkg::SEL_ADDR_HI) begin
        r_next.rdata = r_reg.addr_hi;
      end else if (lnk.sel == fdmcc_pkg::SEL_ADDR_LO) begin
        r_next.rdata = r_reg.addr_lo;
      end else begin
        r_next.rdata = fdmcc_pkg::REG_RESET;
      end
    end
    case (r_reg.st)
      ST_IDLE: begin
        if (lnk.wr) begin
          if (lnk.sel >= fdmcc_pkg::SEL_DATA1 && lnk.sel <= fdmcc_pkg::SEL_DATA4) begin
            r_next.data[2'(lnk.sel - fdmcc_pkg::SEL_DATA1)] = lnk.wdata;
          end else if (lnk.sel == fdmcc_pkg::SEL_ADDR_HI) begin
            r_next.addr_hi = lnk.wdata;
          end else if (lnk.sel == fdmcc_pkg::SEL_ADDR_LO) begin
            r_next.addr_lo = lnk.wdata;
          end else if (lnk.sel == fdmcc_pkg::SEL_CMD) begin
            r_next.cmd_rb = lnk.wdata;
            // Decode by code and mode; unknown codes leave op empty
            case (lnk.wdata)
              fdmcc_pkg::CMD_UPD_ON:  r_next.upd = 1'b1;
              fdmcc_pkg::CMD_UPD_OFF: r_next.upd = 1'b0;
              fdmcc_pkg::CMD_PAGE_RD: begin
                if (!r_reg.upd && addr < fdmcc_pkg::DF_PAGE_LIMIT) begin
                  op = fdmcc_pkg::OP_PG_RD;
                  ln = fdmcc_pkg::PAGE_BYTES;
                  bs = {addr[13:0], 2'b00};
                  cy = fdmcc_pkg::PAGE_RD_CYC;
                end
              end
              fdmcc_pkg::CMD_VERIFY: begin
                if (!r_reg.upd && addr < fdmcc_pkg::DF_PAGE_LIMIT) begin
                  op = fdmcc_pkg::OP_VERIFY;
                  ln = fdmcc_pkg::PAGE_BYTES;
                  bs = {addr[13:0], 2'b00};
                  cy = fdmcc_pkg::PAGE_RD_CYC;
                end
              end
              fdmcc_pkg::CMD_BYTE_RD: begin
                if (!r_reg.upd && addr <= fdmcc_pkg::DF_BYTE_MAX) begin
                  op = fdmcc_pkg::OP_BY_RD;
                  ln = fdmcc_pkg::BYTE_LEN;
                  bs = addr;
                  cy = fdmcc_pkg::BYTE_RD_CYC;
                end
              end
              fdmcc_pkg::CMD_PAGE_WR: begin
                if (!r_reg.upd && addr < fdmcc_pkg::DF_PAGE_LIMIT) begin
                  op = fdmcc_pkg::OP_PG_WR;
                  ln = fdmcc_pkg::PAGE_BYTES;
                  bs = {addr[13:0], 2'b00};
                  cy = PAGE_WR_CYCLES;
                end else if (r_reg.upd && r_reg.addr_hi < fdmcc_pkg::UPD_PAGE_LIMIT) begin
                  op = fdmcc_pkg::OP_PG_WR;
                  ln = fdmcc_pkg::UPD_WR_LEN;
                  bs = {r_reg.addr_hi, 8'h00};
                  cy = UPD_WR_CYCLES;
                end
              end
              fdmcc_pkg::CMD_PAGE_ER: begin
                if (!r_reg.upd && addr < fdmcc_pkg::DF_PAGE_LIMIT) begin
                  op = fdmcc_pkg::OP_PG_ER;
                  ln = fdmcc_pkg::PAGE_BYTES;
                  bs = {addr[13:0], 2'b00};
                  cy = ERASE_CYCLES;
                end else if (r_reg.upd && r_reg.addr_hi < fdmcc_pkg::UPD_PAGE_LIMIT) begin
                  op = fdmcc_pkg::OP_PG_ER;
                  ln = fdmcc_pkg::UPD_ER_LEN;
                  bs = {r_reg.addr_hi, r_reg.addr_lo[7:6], 6'h00};
                  cy = ERASE_CYCLES;
                end
              end
              fdmcc_pkg::CMD_ALL_ER: begin
                op = fdmcc_pkg::OP_ALL_ER;
                ln = r_reg.upd ? fdmcc_pkg::UPD_ALL_LEN : fdmcc_pkg::DF_ALL_LEN;
                cy = ERASE_CYCLES;
              end
              fdmcc_pkg::CMD_BYTE_WR: begin
                if (addr <= (r_reg.upd ? fdmcc_pkg::UPD_BYTE_MAX : fdmcc_pkg::DF_BYTE_MAX)) begin
                  op = fdmcc_pkg::OP_BY_WR;
                  ln = fdmcc_pkg::BYTE_LEN;
                  bs = addr;
                  cy = BYTE_WR_CYCLES;
                end
              end
              default: op = fdmcc_pkg::OP_NONE;
            endcase
            // Start at once on the command write
            if (op != fdmcc_pkg::OP_NONE) begin
              r_next.st   = ST_RUN;
              r_next.op   = op;
              r_next.len  = ln;
              r_next.base = bs;
              r_next.idx  = 16'h0000;
              r_next.mism = 1'b0;
              r_next.cnt  = 32'(cy - 1);
            end
          end
        end
      end
      ST_RUN: begin
        // One array byte per clock until idx reaches len
        if (r_reg.idx < r_reg.len) begin
          r_next.idx = r_reg.idx + 16'h0001;
          if (!r_reg.upd) begin
            case (r_reg.op)
              fdmcc_pkg::OP_PG_RD: r_next.data[r_reg.idx[1:0]] = df_rd;
              fdmcc_pkg::OP_BY_RD: r_next.data[0] = df_rd;
              fdmcc_pkg::OP_VERIFY: begin
                if (df_rd != r_reg.data[r_reg.idx[1:0]]) r_next.mism = 1'b1;
              end
              fdmcc_pkg::OP_PG_WR: begin
                df_we  = 1'b1;
                mem_wd = df_rd & r_reg.data[r_reg.idx[1:0]];
              end
              fdmcc_pkg::OP_BY_WR: begin
                df_we  = 1'b1;
                mem_wd = df_rd & r_reg.data[0];
              end
              default: df_we = 1'b1;
            endcase
          end else begin
            case (r_reg.op)
              fdmcc_pkg::OP_PG_WR: begin
                pf_we  = (r_reg.idx != 16'h0000);
                mem_wd = pf_rd & lnk.internal_external_ram_rdata;
              end
              fdmcc_pkg::OP_BY_WR: begin
                pf_we  = 1'b1;
                mem_wd = pf_rd & r_reg.data[0];
              end
              default: pf_we = 1'b1;
            endcase
          end
        end
        if (r_reg.cnt != 32'h0000_0000) r_next.cnt = r_reg.cnt - 32'h0000_0001;
        // Release the core once walk and timer are done
        if (r_reg.idx == r_reg.len && r_reg.cnt == 32'h0000_0000) begin
          r_next.st = ST_IDLE;
          if (r_reg.op == fdmcc_pkg::OP_VERIFY) begin
            r_next.cmd_rb = r_reg.mism ? fdmcc_pkg::VERIFY_BAD : fdmcc_pkg::VERIFY_OK;
          end
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
  end

  // State register; reset to normal mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_reg         <= '0;
      r_reg.st      <= ST_IDLE;
      r_reg.upd     <= 1'b0;
      r_reg.op      <= fdmcc_pkg::OP_NONE;
      r_reg.cmd_rb  <= fdmcc_pkg::REG_RESET;
      r_reg.code_q  <= fdmcc_pkg::ERASED;
    end else begin
      r_reg <= r_next;
    end
  end

  // Array writes; nonvolatile, so untouched by reset
  always_ff @(posedge sys_clk) begin
    if (df_we) df_mem[df_a] <= mem_wd;
    if (pf_we && pf_a < fdmcc_pkg::UPD_ALL_LEN) pf_mem[pf_a] <= mem_wd;
  end
endmodule

// ===== rtl/fdmcc_core_port.sv
/*
  Core-side end of the flash sequencer link: issues register reads and
  writes, holds while the sequencer stalls, and serves the 256-byte
  page buffer. Assumes the sequencer end on the same sys_clk.
*/
`timescale 1ns/1ps
module fdmcc_core_port (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  fdmcc_link_if.core      lnk,
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [2:0] req_sel,
  input  wire logic [7:0] req_wdata,
  output logic            req_ready,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            core_stalled,
  input  wire logic       internal_external_ram_we,
  input  wire logic [7:0] internal_external_ram_waddr,
  input  wire logic [7:0] internal_external_ram_wdata
);
  typedef enum logic {HS_IDLE, HS_WAIT} fdmcc_hst_t;

  typedef struct packed {
    fdmcc_hst_t st;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] xq;
  } fdmcc_core_t;

  fdmcc_core_t h_reg;
  fdmcc_core_t h_next;
  logic [7:0]  internal_external_ram_mem [0:fdmcc_pkg::INTERNAL_EXTERNAL_RAM_BYTES-1];

  // Hold requests while the sequencer stalls the core
  assign req_ready    = (h_reg.st == HS_IDLE) && !lnk.stall;
  assign lnk.wr       = req_valid && req_ready && req_write;
  assign lnk.rd       = req_valid && req_ready && !req_write;
  assign lnk.sel      = req_sel;
  assign lnk.wdata    = req_wdata;
  assign lnk.internal_external_ram_rdata = h_reg.xq;
  assign rsp_valid    = h_reg.rsp_valid;
  assign rsp_data     = h_reg.rsp_data;
  assign core_stalled = lnk.stall;

  // Read tracking and buffer read port
  always_comb begin
    h_next           = h_reg;
    h_next.rsp_valid = 1'b0;
    h_next.xq        = internal_external_ram_mem[lnk.internal_external_ram_addr];
    case (h_reg.st)
      HS_IDLE: begin
        if (lnk.rd) h_next.st = HS_WAIT;
      end
      HS_WAIT: begin
        if (lnk.rvalid) begin
          h_next.st        = HS_IDLE;
          h_next.rsp_valid = 1'b1;
          h_next.rsp_data  = lnk.rdata;
        end
      end
      default: h_next.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_reg    <= '0;
      h_reg.st <= HS_IDLE;
    end else begin
      h_reg <= h_next;
    end
  end

  // Page buffer filled by the user side
  always_ff @(posedge sys_clk) begin
    if (internal_external_ram_we) internal_external_ram_mem[internal_external_ram_waddr] <= internal_external_ram_wdata;
  end
endmodule

// ===== verification/fdmcc_props.sv
/*
  Checker on the sequencer link: read handshake, stall and op lengths.
  Assumes one sys_clk domain and the shortened cycle parameters.
*/
`timescale 1ns/1ps
module fdmcc_props #(
  parameter int unsigned PAGE_WR_CYCLES = 40,
  parameter int unsigned BYTE_WR_CYCLES = 20,
  parameter int unsigned ERASE_CYCLES   = 60,
  parameter int unsigned UPD_WR_CYCLES  = 300
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] sel,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       stall,
  input wire logic [7:0] internal_external_ram_addr,
  input wire logic [7:0] internal_external_ram_rdata
);
  logic [7:0]  cmd_reg;
  logic [15:0] addr_reg;
  logic        upd_reg;
  logic        upd_at_reg;
  int unsigned cnt_reg;
  int unsigned exp_len;
  logic        cmd_wr;
  logic        vfy_live;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Command strobe and live verify result
  assign cmd_wr = wr && (sel == 3'h0);
  assign vfy_live = !upd_at_reg && cmd_reg == fdmcc_pkg::CMD_VERIFY && addr_reg < 16'h0400;

  // Shadow of command, address, mode and stall length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_reg <= 8'h00;
      addr_reg <= 16'h0000;
      upd_reg <= 1'b0;
      upd_at_reg <= 1'b0;
      cnt_reg <= 0;
    end else begin
      cnt_reg <= stall ? cnt_reg + 1 : 0;
      if (wr && sel == 3'h5) addr_reg[15:8] <= wdata;
      if (wr && sel == 3'h6) addr_reg[7:0] <= wdata;
      if (cmd_wr) begin
        cmd_reg <= wdata;
        upd_at_reg <= upd_reg;
        if (wdata == 8'hF0) upd_reg <= 1'b1;
        if (wdata == 8'h0F) upd_reg <= 1'b0;
      end
    end
  end

  // Expected stall length of the last command, 1 when ignored
  always_comb begin
    exp_len = 1;
    if (!upd_at_reg) begin
      case (cmd_reg)
        8'h01, 8'h04: if (addr_reg < 16'h0400) exp_len = 25;
        8'h02: if (addr_reg < 16'h0400) exp_len = PAGE_WR_CYCLES;
        8'h05: if (addr_reg < 16'h0400) exp_len = ERASE_CYCLES;
        8'h06: exp_len = (ERASE_CYCLES > 4097) ? ERASE_CYCLES : 4097;
        8'h81: if (addr_reg <= 16'h0FFF) exp_len = 10;
        8'h82: if (addr_reg <= 16'h0FFF) exp_len = BYTE_WR_CYCLES;
        default: ;
      endcase
    end else begin
      case (cmd_reg)
        8'h02: if (addr_reg[15:8] < 8'hE0) exp_len = (UPD_WR_CYCLES > 257) ? UPD_WR_CYCLES : 257;
        8'h05: if (addr_reg[15:8] < 8'hE0) exp_len = (ERASE_CYCLES > 65) ? ERASE_CYCLES : 65;
        8'h06: exp_len = 57345;
        8'h82: if (addr_reg <= 16'hDFFF) exp_len = BYTE_WR_CYCLES;
        default: ;
      endcase
    end
  end

  rd_answer_a: assert property (rd |=> rvalid ##1 !rvalid)
    else $error("read answer missing or too long");
  rvalid_cause_a: assert property (rvalid |-> $past(rd))
    else $error("read answer without a read");
  cmd_stall_a: assert property (cmd_wr |=> (stall == (exp_len != 1)))
    else $error("command stall does not match decode");
  stall_start_a: assert property ($rose(stall) |-> $past(cmd_wr))
    else $error("stall rose without a command");
  stall_quiet_a: assert property (stall && !cmd_wr |-> !wr && !rd)
    else $error("core moved while stalled");
  mode_code_a: assert property (cmd_wr && wdata inside {8'hF0, 8'h0F, 8'h03} |=> !stall)
    else $error("mode or reserved code went busy");
  op_length_a: assert property ($fell(stall) |-> cnt_reg == exp_len)
    else $error("operation length wrong");
  readback_a: assert property (rvalid && $past(sel) == 3'h0 |->
    (vfy_live ? rdata <= 8'h01 : rdata == cmd_reg))
    else $error("command readback wrong");

  cover property ($fell(stall) && exp_len == 25);
  cover property (rvalid && vfy_live && rdata == 8'h01);
  cover property (stall && upd_at_reg && internal_external_ram_addr == 8'hFF);
endmodule

// ===== verification/testbench.sv
/*
  Testbench: both link ends joined, driven through register reads and
  writes on the core port. Assumes sys_clk at 100 MHz, shortened timing.
*/
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, rst, req_valid, req_write, internal_external_ram_we, req_ready, rsp_valid, update_mode;
  logic [2:0]  req_sel;
  logic [7:0]  req_wdata, internal_external_ram_waddr, internal_external_ram_wdata, rsp_data, code_data;
  logic [15:0] code_addr;
  logic        core_stalled;
  int          fails, checks;

  fdmcc_link_if link_inst ();
  fdmcc_flash_ctrl #(.PAGE_WR_CYCLES(40), .BYTE_WR_CYCLES(20), .ERASE_CYCLES(60),
    .UPD_WR_CYCLES(300)) fdmcc_flash_ctrl_inst (.sys_clk(sys_clk), .rst(rst),
    .lnk(link_inst.dev), .code_addr(code_addr), .code_data(code_data), .update_mode(update_mode));
  fdmcc_core_port fdmcc_core_port_inst (.sys_clk(sys_clk), .rst(rst), .lnk(link_inst.core),
    .req_valid(req_valid), .req_write(req_write), .req_sel(req_sel), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .core_stalled(core_stalled),
    .internal_external_ram_we(internal_external_ram_we), .internal_external_ram_waddr(internal_external_ram_waddr), .internal_external_ram_wdata(internal_external_ram_wdata));
  // Checker defaults carry the same shortened timing
  fdmcc_props fdmcc_props_inst (.sys_clk(sys_clk), .rst(rst), .sel(link_inst.sel),
    .wr(link_inst.wr), .rd(link_inst.rd), .wdata(link_inst.wdata), .rdata(link_inst.rdata),
    .rvalid(link_inst.rvalid), .stall(link_inst.stall), .internal_external_ram_addr(link_inst.internal_external_ram_addr),
    .internal_external_ram_rdata(link_inst.internal_external_ram_rdata));

  // Free-running core clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One request cycle once the port is ready; a request waits out an earlier command's stall
  task automatic put(input logic [2:0] s, input logic [7:0] d, input logic w);
    repeat (70000) begin
      @(negedge sys_clk);
      if (req_ready === 1'b1) break;
    end
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_sel <= s;
    req_wdata <= d;
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask

  task automatic wr_reg(input logic [2:0] s, input logic [7:0] d);
    put(s, d, 1'b1);
  endtask

  task automatic rd_chk(input logic [2:0] s, input logic [7:0] e);
    put(s, 8'h00, 1'b0);
    repeat (8) begin
      @(negedge sys_clk);
      if (rsp_valid === 1'b1) break;
    end
    chk(rsp_data, e);
  endtask

  task automatic set_addr(input logic [15:0] a);
    wr_reg(3'h5, a[15:8]);
    wr_reg(3'h6, a[7:0]);
  endtask

  task automatic fill(input logic [31:0] d);
    for (int i = 0; i < 4; i++) wr_reg(3'(i + 1), d[8*i+:8]);
  endtask

  task automatic fetch_chk(input logic [15:0] a, input logic [31:0] e);
    set_addr(a);
    wr_reg(3'h0, 8'h01);
    for (int i = 0; i < 4; i++) rd_chk(3'(i + 1), e[8*i+:8]);
  endtask

  task automatic code_chk(input logic [15:0] a, input logic [7:0] e);
    repeat (70000) begin
      @(negedge sys_clk);
      if (core_stalled === 1'b0) break;
    end
    @(posedge sys_clk);
    code_addr <= a;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(code_data, e);
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {req_valid, req_write, internal_external_ram_we} = 3'h0;
    {req_sel, req_wdata, internal_external_ram_waddr, internal_external_ram_wdata, code_addr} = '0;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({7'h00, update_mode}, 8'h00);
    rd_chk(3'h0, 8'h00);
    wr_reg(3'h0, 8'h06);
    @(negedge sys_clk);
    chk({7'h00, core_stalled}, 8'h01);
    set_addr(16'h03FF);
    fill(32'h44332211);
    wr_reg(3'h0, 8'h02);
    fill(32'h00000000);
    fetch_chk(16'h03FF, 32'h44332211);
    set_addr(16'h0400);
    wr_reg(3'h0, 8'h02);
    fetch_chk(16'h0000, 32'hFFFFFFFF);
    set_addr(16'h03FF);
    fill(32'h44332211);
    wr_reg(3'h0, 8'h04);
    rd_chk(3'h0, 8'h00);
    wr_reg(3'h2, 8'h55);
    wr_reg(3'h0, 8'h04);
    rd_chk(3'h0, 8'h01);
    set_addr(16'h0FFD);
    wr_reg(3'h0, 8'h81);
    rd_chk(3'h1, 8'h22);
    set_addr(16'h03FF);
    wr_reg(3'h0, 8'h05);
    fetch_chk(16'h03FF, 32'hFFFFFFFF);
    wr_reg(3'h1, 8'hA5);
    set_addr(16'h0010);
    wr_reg(3'h0, 8'h82);
    fetch_chk(16'h0004, 32'hFFFFFFA5);
    wr_reg(3'h0, 8'h03);
    rd_chk(3'h0, 8'h03);
    wr_reg(3'h0, 8'h77);
    chk({7'h00, update_mode}, 8'h00);
    wr_reg(3'h0, 8'hF0);
    @(negedge sys_clk);
    chk({7'h00, update_mode}, 8'h01);
    chk({7'h00, core_stalled}, 8'h00);
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk);
      internal_external_ram_we <= 1'b1;
      internal_external_ram_waddr <= 8'(i);
      internal_external_ram_wdata <= 8'(i) ^ 8'h5A;
    end
    @(posedge sys_clk);
    internal_external_ram_we <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      set_addr({8'h00, 8'(i * 64 + 5)});
      wr_reg(3'h0, 8'h05);
    end
    set_addr(16'h0000);
    wr_reg(3'h0, 8'h02);
    code_chk(16'h0000, 8'h5A);
    code_chk(16'h00FF, 8'hA5);
    set_addr(16'h0085);
    wr_reg(3'h0, 8'h05);
    code_chk(16'h0080, 8'hFF);
    code_chk(16'h00BF, 8'hFF);
    code_chk(16'h007F, 8'h25);
    code_chk(16'h00C0, 8'h9A);
    wr_reg(3'h1, 8'h3C);
    set_addr(16'hDFC0);
    wr_reg(3'h0, 8'h05);
    set_addr(16'hDFFF);
    wr_reg(3'h0, 8'h82);
    code_chk(16'hDFFF, 8'h3C);
    set_addr(16'hE000);
    wr_reg(3'h0, 8'h82);
    code_chk(16'hE000, 8'hFF);
    fetch_chk(16'h0000, 32'hFFFFFF3C);
    wr_reg(3'h0, 8'h0F);
    @(negedge sys_clk);
    chk({7'h00, update_mode}, 8'h00);
    conclude();
  end
endmodule
